/* File: rtl/data_memory_status_unit.sv */
// How it works
// - Banked RAM at 40H-FFH, bank chosen by select through pointer 1
// - 00H/02H reach memory via pointer 0/1
// - Indirect to indirect port: read zero, write ignored
// - Pointer 0 uses bank 0, pointer 1 bank select
// - Indirect low addresses always act as bank 0
// - Pointers 8 bits, bank select 6 or 5
// - Working register at 05H, pairs with immediates
// - Memory-to-memory moves pass through working register
// - ALU: add/sub, decimal adjust, logic, rotates, inc/dec, tests
// - ALU writes result; all ops but RL/RR/TSTZ update flags
// - Status writes change arithmetic flags only
// - Dog flag changed only by reset/timeout/kick/halt
// - Dog flag cleared by reset/kick/halt, set timeout
// - Halted flag changed only by halt/kick/reset
// - Halted cleared by reset/kick, set by halt
// - Arithmetic flags show latest affecting operation
// - Calls save PC only, never status
// - Unassigned addresses below 40H read zero
module data_memory_status_unit #(
  parameter int BANKS = 15,          // RAM banks fitted
  parameter int BANK_W = 6           // Bank select width
) (
  input wire logic i_sys_clk,                      // System clock
  input wire logic i_reset,                        // Sync reset, high
  input wire dmem_pkg::exec_req_t i_req,           // Execute step
  input wire logic i_dog_timeout,                  // Watchdog expiry pulse
  input wire logic i_dog_kick,                     // Watchdog clear instruction
  input wire logic i_halt,                         // Halt instruction
  input wire logic [7:0] i_ecr_rdata,              // Peripheral read data
  output dmem_pkg::exec_rsp_t o_rsp,               // Result of step
  output dmem_pkg::ecr_bus_t o_ecr,                // Peripheral strobes
  output logic [7:0] o_status,                     // Status flags
  output logic [7:0] o_working                     // Working register
);
  import dmem_pkg::*;

  localparam int RAM_WORDS = 192;

  typedef struct packed {
    logic [7:0] wreg;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [BANK_W-1:0] bank;
    logic [7:0] status;
    exec_rsp_t rsp;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // RAM kept outside the state struct: it has no reset value
  logic [7:0] ram_r [BANKS*RAM_WORDS];

  logic is_ind;
  logic [7:0] eff_addr;
  logic [BANK_W-1:0] eff_bank;
  logic ind_self;
  logic [7:0] rd_data;
  logic [ECR_SEL_W-1:0] ecr_sel;
  logic ecr_hit;
  int ram_idx;
  logic [7:0] opa;
  logic [7:0] res;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic c_new, ac_new, ov_new;
  logic c_upd, a_upd;
  logic wr_en;

  always_comb begin
    // Effective address resolution through pointers
    is_ind = (i_req.addr == ADDR_IND0) || (i_req.addr == ADDR_IND1);
    eff_addr = i_req.addr;
    eff_bank = '0;
    if (i_req.addr == ADDR_IND0) begin
      eff_addr = state_r.ptr0;
      eff_bank = '0;
    end else if (i_req.addr == ADDR_IND1) begin
      eff_addr = state_r.ptr1;
      eff_bank = state_r.bank;
    end
    if (eff_addr < ADDR_RAM_LO) begin
      eff_bank = '0;
    end
    ind_self = is_ind && ((eff_addr == ADDR_IND0) || (eff_addr == ADDR_IND1));
    ram_idx = int'(eff_bank) * RAM_WORDS + int'(eff_addr - ADDR_RAM_LO);

    // Embedded control register decode
    ecr_hit = 1'b1;
    case (eff_addr)
      ADDR_TONE_CTL: ecr_sel = ECR_SEL_W'(1 << 0);
      ADDR_TONE_DIG: ecr_sel = ECR_SEL_W'(1 << 1);
      ADDR_LINE: ecr_sel = ECR_SEL_W'(1 << 2);
      ADDR_CLK_CAL: ecr_sel = ECR_SEL_W'(1 << 3);
      ADDR_OP_MODE: ecr_sel = ECR_SEL_W'(1 << 4);
      ADDR_FDIV_CTL: ecr_sel = ECR_SEL_W'(1 << 5);
      ADDR_FDIV_DAT: ecr_sel = ECR_SEL_W'(1 << 6);
      ADDR_PF_DAT: ecr_sel = ECR_SEL_W'(1 << 7);
      ADDR_PF_DIR: ecr_sel = ECR_SEL_W'(1 << 8);
      ADDR_PG_DAT: ecr_sel = ECR_SEL_W'(1 << 9);
      ADDR_PG_DIR: ecr_sel = ECR_SEL_W'(1 << 10);
      default: begin
        ecr_sel = '0;
        ecr_hit = 1'b0;
      end
    endcase

    // Read mux
    rd_data = BYTE_ZERO;
    if (ind_self) begin
      rd_data = BYTE_ZERO;
    end else if (eff_addr >= ADDR_RAM_LO) begin
      if (int'(eff_bank) < BANKS) begin
        rd_data = ram_r[ram_idx];
      end
    end else if (ecr_hit) begin
      rd_data = i_ecr_rdata;
    end else begin
      case (eff_addr)
        ADDR_PTR0: rd_data = state_r.ptr0;
        ADDR_PTR1: rd_data = state_r.ptr1;
        ADDR_BANK: rd_data = 8'(state_r.bank);
        ADDR_WREG: rd_data = state_r.wreg;
        ADDR_STAT: rd_data = state_r.status;
        default: rd_data = BYTE_ZERO;
      endcase
    end

    // ALU: operand A is the immediate or the memory byte
    opa = i_req.use_imm ? i_req.imm : rd_data;
    res = BYTE_ZERO;
    sum9 = '0;
    sum5 = '0;
    c_new = state_r.status[ST_C];
    ac_new = state_r.status[ST_AC];
    ov_new = state_r.status[ST_OV];
    c_upd = 1'b0;
    a_upd = 1'b0;
    case (i_req.op)
      OP_ADD, OP_ADC: begin
        sum9 = {1'b0, state_r.wreg} + {1'b0, opa} + 9'((i_req.op == OP_ADC) & state_r.status[ST_C]);
        sum5 = {1'b0, state_r.wreg[3:0]} + {1'b0, opa[3:0]} + 5'((i_req.op == OP_ADC) & state_r.status[ST_C]);
        res = sum9[7:0];
        c_new = sum9[8];
        ac_new = sum5[4];
        ov_new = (state_r.wreg[7] == opa[7]) && (res[7] != opa[7]);
        a_upd = 1'b1;
      end
      OP_SUB, OP_SBC: begin
        // Carry means no borrow
        sum9 = {1'b0, opa} + {1'b0, ~state_r.wreg} + 9'((i_req.op == OP_SUB) | state_r.status[ST_C]);
        sum5 = {1'b0, opa[3:0]} + {1'b0, ~state_r.wreg[3:0]} + 5'((i_req.op == OP_SUB) | state_r.status[ST_C]);
        res = sum9[7:0];
        c_new = sum9[8];
        ac_new = sum5[4];
        ov_new = (opa[7] != state_r.wreg[7]) && (res[7] != opa[7]);
        a_upd = 1'b1;
      end
      OP_DAA: begin
        // Only carry and zero are touched; AC and OV keep their value
        sum9 = {1'b0, opa};
        if ((opa[3:0] > NIB_NINE) || state_r.status[ST_AC]) begin
          sum9 = sum9 + {1'b0, DAA_LO};
        end
        if ((sum9[7:4] > NIB_NINE) || sum9[8] || state_r.status[ST_C]) begin
          sum9 = sum9 + {1'b0, DAA_HI};
        end
        res = sum9[7:0];
        c_new = sum9[8] | state_r.status[ST_C];
        c_upd = 1'b1;
      end
      OP_AND: res = state_r.wreg & opa;
      OP_OR: res = state_r.wreg | opa;
      OP_XOR: res = state_r.wreg ^ opa;
      OP_CPL: res = ~opa;
      OP_RL: res = {opa[6:0], opa[7]};
      OP_RR: res = {opa[0], opa[7:1]};
      OP_RLC: begin
        res = {opa[6:0], state_r.status[ST_C]};
        c_new = opa[7];
        c_upd = 1'b1;
      end
      OP_RRC: begin
        res = {state_r.status[ST_C], opa[7:1]};
        c_new = opa[0];
        c_upd = 1'b1;
      end
      OP_INC: res = opa + BYTE_ONE;
      OP_DEC: res = opa - BYTE_ONE;
      OP_MOV, OP_TSTZ: res = opa;
      default: res = opa;
    endcase

    // Next state
    state_nxt = state_r;
    wr_en = 1'b0;
    if (i_req.valid) begin
      // Result stands until the next step, so idle cycles cannot disturb it
      state_nxt.rsp.data = res;
      state_nxt.rsp.zero = (res == BYTE_ZERO);
      state_nxt.rsp.skip = (i_req.op != OP_NONE) && (res == BYTE_ZERO);
      // Flags land with the result, so the next step sees them
      if (i_req.op inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC}) begin
        state_nxt.status[ST_C] = c_new;
        state_nxt.status[ST_AC] = ac_new;
        state_nxt.status[ST_OV] = ov_new;
      end else if (c_upd) begin
        state_nxt.status[ST_C] = c_new;
      end
      if (!(i_req.op inside {OP_NONE, OP_RL, OP_RR, OP_RLC, OP_RRC, OP_TSTZ})) begin
        state_nxt.status[ST_Z] = (res == BYTE_ZERO);
      end
      // One port: either memory or the working register gets the result
      if (i_req.to_mem || i_req.wr_mem_only) begin
        wr_en = !ind_self;
      end else if (i_req.op != OP_NONE) begin
        state_nxt.wreg = res;
      end
      if (wr_en && !is_ind || wr_en && is_ind) begin
        if (eff_addr < ADDR_RAM_LO) begin
          case (eff_addr)
            ADDR_PTR0: state_nxt.ptr0 = res;
            ADDR_PTR1: state_nxt.ptr1 = res;
            ADDR_BANK: state_nxt.bank = res[BANK_W-1:0];
            ADDR_WREG: state_nxt.wreg = res;
            ADDR_STAT: begin
              state_nxt.status[ST_OV:ST_C] = res[ST_OV:ST_C];
            end
            default: state_nxt.wreg = state_nxt.wreg;
          endcase
        end
      end
    end
    // Halt and watchdog flags come only from their own events
    if (i_dog_kick) begin
      state_nxt.status[ST_HALT] = 1'b0;
      state_nxt.status[ST_DOG] = 1'b0;
    end
    if (i_halt) begin
      state_nxt.status[ST_HALT] = 1'b1;
      state_nxt.status[ST_DOG] = 1'b0;
    end
    if (i_dog_timeout) begin
      state_nxt.status[ST_DOG] = 1'b1;
    end
    state_nxt.status[7:6] = 2'b00;
  end

  // Strobes are combinational so the peripheral sees them in the step
  always_comb begin
    o_ecr.sel = ecr_sel;
    o_ecr.rd = i_req.valid && ecr_hit && !ind_self;
    o_ecr.wr = i_req.valid && ecr_hit && wr_en;
    o_ecr.wdata = res;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
    if (!i_reset && wr_en && (eff_addr >= ADDR_RAM_LO) && (int'(eff_bank) < BANKS)) begin
      ram_r[ram_idx] <= res;
    end
  end

  // Status is never pushed on a call; the core saves only the PC
  assign o_status = state_r.status;
  assign o_working = state_r.wreg;
  assign o_rsp = state_r.rsp;

endmodule : data_memory_status_unit

/* File: pkg/dmem_pkg.sv */
package dmem_pkg;

  // Data memory map
  localparam logic [7:0] ADDR_IND0 = 8'h00;
  localparam logic [7:0] ADDR_PTR0 = 8'h01;
  localparam logic [7:0] ADDR_IND1 = 8'h02;
  localparam logic [7:0] ADDR_PTR1 = 8'h03;
  localparam logic [7:0] ADDR_BANK = 8'h04;
  localparam logic [7:0] ADDR_WREG = 8'h05;
  localparam logic [7:0] ADDR_STAT = 8'h0A;
  localparam logic [7:0] ADDR_ECR_LO = 8'h20;
  localparam logic [7:0] ADDR_ECR_HI = 8'h3F;
  localparam logic [7:0] ADDR_RAM_LO = 8'h40;
  localparam logic [7:0] ADDR_TONE_CTL = 8'h20;
  localparam logic [7:0] ADDR_TONE_DIG = 8'h21;
  localparam logic [7:0] ADDR_LINE = 8'h22;
  localparam logic [7:0] ADDR_CLK_CAL = 8'h24;
  localparam logic [7:0] ADDR_OP_MODE = 8'h26;
  localparam logic [7:0] ADDR_FDIV_CTL = 8'h2E;
  localparam logic [7:0] ADDR_FDIV_DAT = 8'h2F;
  localparam logic [7:0] ADDR_PF_DAT = 8'h34;
  localparam logic [7:0] ADDR_PF_DIR = 8'h35;
  localparam logic [7:0] ADDR_PG_DAT = 8'h36;
  localparam logic [7:0] ADDR_PG_DIR = 8'h37;
  localparam int ECR_SEL_W = 11;

  // Status flag bit positions
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_HALT = 4;
  localparam int ST_DOG = 5;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] NIB_NINE = 4'h9;
  localparam logic [7:0] DAA_LO = 8'h06;
  localparam logic [7:0] DAA_HI = 8'h60;
  localparam logic [2:0] LOW_ADDR_MSBS = 3'h0;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD  = 5'h01,
    OP_ADC  = 5'h02,
    OP_SUB  = 5'h03,
    OP_SBC  = 5'h04,
    OP_DAA  = 5'h05,
    OP_AND  = 5'h06,
    OP_OR   = 5'h07,
    OP_XOR  = 5'h08,
    OP_CPL  = 5'h09,
    OP_RL   = 5'h0A,
    OP_RR   = 5'h0B,
    OP_RLC  = 5'h0C,
    OP_RRC  = 5'h0D,
    OP_INC  = 5'h0E,
    OP_DEC  = 5'h0F,
    OP_MOV  = 5'h10,
    OP_TSTZ = 5'h11
  } alu_op_t;

  // One instruction-step request from the core
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    alu_op_t op;
    logic use_imm;
    logic [7:0] imm;
    logic to_mem;
    logic wr_mem_only;
  } exec_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic zero;
    logic skip;
  } exec_rsp_t;

  typedef struct packed {
    logic [ECR_SEL_W-1:0] sel;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } ecr_bus_t;

endpackage : dmem_pkg

/* File: dv/periph_model.sv */
module periph_model (
  input wire logic i_sys_clk,            // System clock
  input wire dmem_pkg::ecr_bus_t i_ecr,  // Strobes from the unit
  output logic [7:0] o_rdata             // Read data back
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmem_pkg::*;
  logic [7:0] regs_r [ECR_SEL_W];
  logic [7:0] last_r;
  logic [7:0] val;
  always_comb begin
    val = 8'h00;
    for (int k = 0; k < ECR_SEL_W; k++) begin
      if (i_ecr.sel[k]) val |= regs_r[k];
    end
  end
  // Idle bus shows a changed value so a stale read cannot pass
  assign o_rdata = i_ecr.rd ? val : ~last_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_ecr.rd) last_r <= val;
    for (int k = 0; k < ECR_SEL_W; k++) begin
      if (i_ecr.wr && i_ecr.sel[k]) regs_r[k] <= i_ecr.wdata;
    end
  end
endmodule : periph_model

/* File: dv/dmem_properties.sv */
module dmem_checker #(
  parameter int BANKS = 15,  // RAM banks fitted
  parameter int BANK_W = 6   // Bank select width
) (
  input wire logic i_sys_clk,              // Clock
  input wire logic i_reset,                // Reset
  input wire dmem_pkg::exec_req_t i_req,   // Step
  input wire logic i_dog_timeout,          // Timeout
  input wire logic i_dog_kick,             // Kick
  input wire logic i_halt,                 // Halt
  input wire logic [7:0] i_ecr_rdata,      // Peripheral data
  input wire dmem_pkg::exec_rsp_t o_rsp,   // Result
  input wire dmem_pkg::ecr_bus_t o_ecr,    // Strobes
  input wire logic [7:0] o_status,         // Status
  input wire logic [7:0] o_working         // Working register
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmem_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  wire logic mov_imm = i_req.valid && i_req.op == OP_MOV && i_req.use_imm && !i_req.to_mem && !i_req.wr_mem_only;
  wire logic add_imm = i_req.valid && i_req.op == OP_ADD && i_req.use_imm && !i_req.to_mem && !i_req.wr_mem_only;
  a_spare_zero: assert property (o_status[7:6] == 2'h0) else $error("status spare bits set");
  a_dog_set: assert property (i_dog_timeout |=> o_status[ST_DOG]) else $error("dog flag not set");
  a_dog_clear: assert property ((i_dog_kick || i_halt) && !i_dog_timeout |=> !o_status[ST_DOG])
    else $error("dog flag not cleared");
  a_dog_hold: assert property (!i_dog_timeout && !i_dog_kick && !i_halt |=> $stable(o_status[ST_DOG]))
    else $error("dog flag changed");
  a_halt_set: assert property (i_halt |=> o_status[ST_HALT]) else $error("halted flag not set");
  a_halt_clear: assert property (i_dog_kick && !i_halt |=> !o_status[ST_HALT])
    else $error("halted flag not cleared");
  a_halt_hold: assert property (!i_halt && !i_dog_kick |=> $stable(o_status[ST_HALT]))
    else $error("halted flag changed");
  a_strobe_idle: assert property (!i_req.valid |-> !o_ecr.rd && !o_ecr.wr) else $error("strobe when idle");
  a_tone_sel: assert property (i_req.valid && i_req.addr == 8'h20 |-> o_ecr.sel == 11'h001)
    else $error("wrong peripheral select");
  a_wreg_load: assert property (mov_imm |=> o_working == $past(i_req.imm)) else $error("working load wrong");
  a_add_result: assert property (add_imm |=> o_working == 8'($past(i_req.imm) + $past(o_working)))
    else $error("add result wrong");
  c_timeout: cover property (i_dog_timeout ##1 o_status[ST_DOG]);
  c_halt: cover property (i_halt ##1 o_status[ST_HALT]);
  c_ecr_wr: cover property (o_ecr.wr);
  c_add: cover property (add_imm);
endmodule : dmem_checker
bind data_memory_status_unit dmem_checker #(.BANKS(BANKS), .BANK_W(BANK_W)) u_dmem_checker (.*);

/* File: dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dmem_pkg::*;
  logic i_sys_clk = 0, i_reset = 1, chk = 0, pend = 0;
  logic [2:0] ev = 3'h0;
  exec_req_t req = '0;
  exec_rsp_t rsp;
  ecr_bus_t ecr;
  logic [7:0] rdata, status, working, a, b, note;
  logic [8:0] e;
  logic [7:0] exp_q [$];
  logic [31:0] seed = 34007;
  int mismatches = 0, compares = 0, cyc = 0;
  logic [7:0] ea [11] = '{8'h20, 8'h21, 8'h22, 8'h24, 8'h26, 8'h2E, 8'h2F, 8'h34, 8'h35, 8'h36, 8'h37};
  alu_op_t ops [8] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_INC, OP_DEC};
  data_memory_status_unit u_data_memory_status_unit (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_req(req),
    .i_dog_timeout(ev[2]), .i_dog_kick(ev[1]), .i_halt(ev[0]), .i_ecr_rdata(rdata), .o_rsp(rsp),
    .o_ecr(ecr), .o_status(status), .o_working(working));
  periph_model u_periph_model (.i_sys_clk(i_sys_clk), .i_ecr(ecr), .o_rdata(rdata));
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [8:0] ref_alu(input alu_op_t op, input logic [7:0] x, y);
    case (op)
      OP_ADD: return 9'(x) + 9'(y);
      OP_SUB: return {x >= y, x - y};
      OP_AND: return {1'b0, x & y};
      OP_OR: return {1'b0, x | y};
      OP_XOR: return {1'b0, x ^ y};
      OP_CPL: return {1'b0, ~x};
      OP_INC: return {1'b0, x + 8'h01};
      default: return {1'b0, x - 8'h01};
    endcase
  endfunction : ref_alu
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    compares++;
    if (seen !== expv) begin
      mismatches++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check
  task automatic step(input logic [7:0] ad, input alu_op_t op, input logic ui, tm, ck, input logic [7:0] im, ex);
    @(negedge i_sys_clk);
    req = '{valid: 1'b1, addr: ad, op: op, use_imm: ui, imm: im, to_mem: tm, wr_mem_only: 1'b0};
    chk = ck;
    if (ck) exp_q.push_back(ex);
  endtask : step
  task automatic wr(input logic [7:0] ad, v);
    step(ad, OP_MOV, 1'b1, 1'b1, 1'b0, v, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] ad, ex);
    step(ad, OP_MOV, 1'b0, 1'b0, 1'b1, 8'h00, ex);
  endtask : rd
  task automatic idle(input logic [2:0] e3);
    @(negedge i_sys_clk);
    req.valid = 1'b0;
    chk = 1'b0;
    ev = e3;
    @(negedge i_sys_clk);
    ev = 3'h0;
  endtask : idle
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  always @(posedge i_sys_clk) begin
    pend <= req.valid & chk;
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      results();
    end
  end
  // Oldest note is the result of the step one edge back
  always @(negedge i_sys_clk) begin
    if (pend) begin
      // Every step used here has a real op, so skip follows the zero result
      note = exp_q.pop_front();
      check({rsp.skip, rsp.zero, rsp.data}, {note == 8'h00, note == 8'h00, note});
    end
  end
  initial begin
    repeat (20) @(negedge i_sys_clk);
    i_reset = 0;
    check(status, 8'h00);
    check(working, 8'h00);
    a = rnd();
    b = rnd();
    wr(8'h01, 8'h45); wr(8'h03, 8'h45); wr(8'h04, 8'h01);
    wr(8'h02, a); wr(8'h00, b); rd(8'h02, a); rd(8'h00, b);
    wr(8'h04, 8'h00); rd(8'h02, b);
    wr(8'h04, 8'h03); wr(8'h03, 8'h05); wr(8'h05, 8'h7E); rd(8'h02, 8'h7E);
    wr(8'h01, 8'h00); wr(8'h00, 8'h55); rd(8'h00, 8'h00);
    wr(8'h10, 8'h5A); rd(8'h10, 8'h00);
    wr(8'h01, 8'hFF); rd(8'h01, 8'hFF); wr(8'h04, 8'hFF); rd(8'h04, 8'h3F);
    idle(3'b100); check(status & 8'h30, 8'h20);
    idle(3'b001); check(status & 8'h30, 8'h10);
    idle(3'b100);
    wr(ADDR_STAT, 8'hFF);
    rd(ADDR_STAT, 8'h3F);
    idle(3'b000); check(status & 8'hF0, 8'h30);
    idle(3'b010); check(status & 8'h30, 8'h00);
    for (int i = 0; i < 11; i++) begin
      a = rnd();
      wr(ea[i], a);
      #1 check({ecr.wr, ecr.sel}, 16'h800 | (16'h1 << i));
      rd(ea[i], a);
      #1 check({ecr.rd, ecr.sel}, 16'h800 | (16'h1 << i));
    end
    for (int r = 0; r < 3; r++) begin
      foreach (ops[k]) begin
        a = (r == 0) ? 8'h80 : rnd();
        b = (r == 0) ? 8'h80 : rnd();
        e = ref_alu(ops[k], a, b);
        step(8'h40, OP_MOV, 1'b1, 1'b0, 1'b0, b, 8'h00);
        step(8'h40, ops[k], 1'b1, 1'b0, 1'b1, a, e[7:0]);
        idle(3'b000);
        check({status[ST_Z], status[ST_C] & (k < 2)}, {~|e[7:0], e[8] & (k < 2)});
      end
    end
    // Carry chain, rotates, decimal adjust and the zero test
    step(8'h40, OP_MOV, 1'b1, 1'b0, 1'b0, 8'h80, 8'h00);
    step(8'h40, OP_ADD, 1'b1, 1'b0, 1'b1, 8'h80, 8'h00);
    step(8'h40, OP_ADC, 1'b1, 1'b0, 1'b1, 8'h05, 8'h06);
    step(8'h40, OP_RLC, 1'b1, 1'b0, 1'b1, 8'h81, 8'h02);
    step(8'h40, OP_RRC, 1'b1, 1'b0, 1'b1, 8'h02, 8'h81);
    step(8'h40, OP_RL, 1'b1, 1'b0, 1'b1, 8'h81, 8'h03);
    step(8'h40, OP_RR, 1'b1, 1'b0, 1'b1, 8'h81, 8'hC0);
    step(8'h40, OP_SBC, 1'b1, 1'b0, 1'b1, 8'hC5, 8'h04);
    idle(3'b000);
    check(status & 8'h0F, 8'h03);
    step(8'h40, OP_ADD, 1'b1, 1'b0, 1'b1, 8'h01, 8'h05);
    step(8'h40, OP_DAA, 1'b1, 1'b0, 1'b1, 8'h1A, 8'h20);
    step(8'h40, OP_TSTZ, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
    idle(3'b000);
    check(status & 8'h0F, 8'h00);
    idle(3'b000);
    results();
  end
endmodule : testbench
